// *** src/efsr_defs.svh ***
`ifndef EFSR_DEFS_SVH
`define EFSR_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define EFSR_ADDR_W 6
`define EFSR_OFS_FLAGS 6'h2B
`define EFSR_OFS_RESET_CMD 6'h2F
`define EFSR_OFS_MINUTES 6'h02
`define EFSR_FLAGS_RST 8'h00

// ****************************************
// Flag bit positions
// ****************************************
`define EFSR_BIT_PERIODIC 7
`define EFSR_BIT_ALARM2 6
`define EFSR_BIT_ALARM1 5
`define EFSR_BIT_WATCHDOG 4
`define EFSR_BIT_SWITCHOVER 3
`define EFSR_BIT_CAPTURE3 2
`define EFSR_BIT_CAPTURE2 1
`define EFSR_BIT_CAPTURE1 0
`define EFSR_BIT_EVENT_MON 7

// ****************************************
// Command codes
// ****************************************
`define EFSR_CMD_SOFT_RESET 8'h2C
`define EFSR_CMD_PRESC_CLEAR 8'hA4
`define EFSR_CMD_CAPT_CLEAR 8'h25
`define EFSR_CMD_BOTH_CLEAR 8'hA5

// ****************************************
// Reset image of the rest of the device
// ****************************************
`define EFSR_RST_HUNDREDTHS 8'h00
`define EFSR_RST_SECONDS 8'h80
`define EFSR_RST_MINUTES 8'h00
`define EFSR_RST_HOURS 8'h00
`define EFSR_RST_DAYS 8'h01
`define EFSR_RST_WEEKDAYS 8'h06
`define EFSR_RST_MONTHS 8'h01
`define EFSR_RST_YEARS 8'h00
`define EFSR_RST_OTHER 8'h00
`define EFSR_ALARM_FIRST 6'h08
`define EFSR_ALARM_LAST 6'h0F
`define EFSR_CAPT_FIRST 6'h11
`define EFSR_CAPT_LAST 6'h22
`define EFSR_STOP_ENABLE 6'h2E

// ****************************************
// Timing
// ****************************************
`define EFSR_PRESC_DIV 82

`endif

// *** src/efsr_pkg.sv ***
package efsr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } efsr_req_t;

  typedef struct packed {
    logic soft_reset;
    logic presc_clear;
    logic capt_clear;
  } efsr_cmd_t;

  typedef enum logic [1:0] {
    EFSR_POR,
    EFSR_RUN
  } efsr_state_t;

endpackage : efsr_pkg

// *** src/efsr_top.sv ***
`timescale 1ns/10ps
`include "efsr_defs.svh"

// Operation
// - Flag byte: tick bit 7, alarms 6..5, watchdog, switch-over, captures 2..0.
// - A flag bit reads 1 when active, 0 otherwise; all zero after reset.
// - Writing 0 clears a flag; writing 1 leaves it unchanged.
// - Flags set by their function and held until cleared by a host write.
// - Flag write result is written byte ANDed with current flags.
// - All flags ORed into event monitor, read as minutes register MSB.
// - Command 2Ch: full soft reset, including prescaler and capture clears.
// - Command A4h: clear prescaler chain only.
// - Command 25h: clear all capture slot registers only.
// - Command A5h: prescaler clear and capture clear together.
// - Any other command byte does nothing.
// - Power-on produces the same reset as the soft reset command.
// - Reset gives calendar mode, hundredths off, 00:00:00.00, 2000.01.01, Saturday.
// - Reset enables switch-over at lower threshold, oscillator load 7 pF.
// - Reset: interrupt A and clock pin give 32 kHz, capture pin disabled.
// - Alarm registers 08h to 0Fh keep their values across reset.
// - Other registers reset to zero except seconds, days, weekday, months; 2Eh kept.
// - Capture clear zeroes capture registers 11h to 22h.
// - Prescaler clear resets the 8.192 kHz tick divider while halted.
module efsr_top
  import efsr_pkg::*;
#(
  parameter int PRESC_DIV = `EFSR_PRESC_DIV
) (
  input wire logic mclk,
  input wire logic reset,
  input wire efsr_req_t reg_req,
  input wire logic [7:0] flag_set,
  input wire logic tick_8k192,
  input wire logic halt,
  output logic [7:0] reg_rdata_q,
  output logic [7:0] flags_q,
  output logic event_monitor_bit_q,
  output efsr_cmd_t cmd_q,
  output logic reg_reset_q,
  output logic sys_tick_q
);

  localparam int PW = $clog2(PRESC_DIV);

  // ****************************************
  // Command decode
  // ****************************************
  efsr_cmd_t cmd_d;
  logic cmd_wr;

  always_comb begin
    cmd_wr = reg_req.wr && (reg_req.addr == `EFSR_OFS_RESET_CMD);
    cmd_d = '0;
    if (cmd_wr) begin
      // Value is decoded, never stored
      case (reg_req.wdata)
        `EFSR_CMD_SOFT_RESET: cmd_d = '{soft_reset: 1'b1, presc_clear: 1'b1,
                                        capt_clear: 1'b1};
        `EFSR_CMD_PRESC_CLEAR: cmd_d.presc_clear = 1'b1;
        `EFSR_CMD_CAPT_CLEAR: cmd_d.capt_clear = 1'b1;
        `EFSR_CMD_BOTH_CLEAR: begin
          cmd_d.presc_clear = 1'b1;
          cmd_d.capt_clear = 1'b1;
        end
        default: cmd_d = '0;
      endcase
    end
  end

  // ****************************************
  // Power-on and soft reset sequencing
  // ****************************************
  efsr_state_t state_q;
  efsr_state_t state_d;
  logic reg_reset_d;

  // Power-on runs through the same pulse as the soft command
  always_comb begin
    state_d = state_q;
    reg_reset_d = 1'b0;
    case (state_q)
      EFSR_POR: begin
        state_d = EFSR_RUN;
        reg_reset_d = 1'b1;
      end
      EFSR_RUN: begin
        // Pulse loads the reset image held in the defines header
        reg_reset_d = cmd_d.soft_reset;
      end
      default: state_d = EFSR_POR;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= EFSR_POR;
      reg_reset_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      reg_reset_q <= reg_reset_d;
      cmd_q <= cmd_d;
    end
  end

  // ****************************************
  // Flag register
  // ****************************************
  logic [7:0] flags_d;
  logic [7:0] keep_mask;
  logic flags_wr;
  logic event_monitor_bit_d;

  always_comb begin
    flags_wr = reg_req.wr && (reg_req.addr == `EFSR_OFS_FLAGS);
    keep_mask = flags_wr ? reg_req.wdata : 8'hFF;
    // Set ORed after the AND so a host write never loses an event
    flags_d = (flags_q & keep_mask) | flag_set;
    if (reg_reset_d) begin
      flags_d = `EFSR_FLAGS_RST;
    end
    event_monitor_bit_d = |flags_d;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_q <= `EFSR_FLAGS_RST;
      event_monitor_bit_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      event_monitor_bit_q <= event_monitor_bit_d;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = reg_rdata_q;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `EFSR_OFS_FLAGS: rdata_d = flags_q;
        `EFSR_OFS_MINUTES: begin
          rdata_d = 8'h00;
          rdata_d[`EFSR_BIT_EVENT_MON] = event_monitor_bit_q;
        end
        default: rdata_d = 8'h00; // Command register reads zero
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Tick prescaler
  // ****************************************
  logic [PW-1:0] presc_q;
  logic [PW-1:0] presc_d;
  logic sys_tick_d;

  // Frozen while halted so a clear lands on a still chain
  always_comb begin
    presc_d = presc_q;
    sys_tick_d = 1'b0;
    if (cmd_d.presc_clear || reg_reset_d) begin
      presc_d = '0;
    end else if (tick_8k192 && !halt) begin
      if (presc_q == PW'(PRESC_DIV - 1)) begin
        presc_d = '0;
        sys_tick_d = 1'b1;
      end else begin
        presc_d = presc_q + PW'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      presc_q <= '0;
      sys_tick_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      sys_tick_q <= sys_tick_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  flag_set_wins_a: assert property (@(posedge mclk) disable iff (reset)
    (|flag_set && !reg_reset_d) |=> ((flags_q & $past(flag_set)) == $past(flag_set)))
    else $error("flag set lost");

  flag_and_write_a: assert property (@(posedge mclk) disable iff (reset)
    (flags_wr && !reg_reset_d)
      |=> flags_q == (($past(flags_q) & $past(reg_req.wdata)) | $past(flag_set)))
    else $error("flag write not AND");

  flag_hold_a: assert property (@(posedge mclk) disable iff (reset)
    (!flags_wr && !reg_reset_d && flag_set == 8'h00) |=> $stable(flags_q))
    else $error("flag changed without cause");

  event_mon_or_a: assert property (@(posedge mclk) disable iff (reset)
    event_monitor_bit_q == (|flags_q))
    else $error("event monitor mismatch");

  soft_reset_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_SOFT_RESET && state_q == EFSR_RUN)
      |=> cmd_q.soft_reset && cmd_q.presc_clear && cmd_q.capt_clear && reg_reset_q
      && flags_q == `EFSR_FLAGS_RST)
    else $error("soft reset incomplete");

  presc_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_PRESC_CLEAR)
      |=> cmd_q.presc_clear && !cmd_q.capt_clear && !cmd_q.soft_reset && presc_q == '0)
    else $error("prescaler clear wrong");

  capt_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_CAPT_CLEAR)
      |=> cmd_q.capt_clear && !cmd_q.presc_clear && !cmd_q.soft_reset)
    else $error("capture clear wrong");

  both_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_BOTH_CLEAR)
      |=> cmd_q.capt_clear && cmd_q.presc_clear && !cmd_q.soft_reset)
    else $error("combined clear wrong");

  other_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    !(cmd_wr && reg_req.wdata inside {`EFSR_CMD_SOFT_RESET, `EFSR_CMD_PRESC_CLEAR,
      `EFSR_CMD_CAPT_CLEAR, `EFSR_CMD_BOTH_CLEAR}) |=> cmd_q == '0)
    else $error("unknown command acted");

  cmd_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_q.capt_clear && !cmd_wr) |=> !cmd_q.capt_clear)
    else $error("command not a pulse");

  por_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(state_q == EFSR_RUN) |-> reg_reset_q && flags_q == `EFSR_FLAGS_RST)
    else $error("power-on reset missing");

  halt_freeze_a: assert property (@(posedge mclk) disable iff (reset)
    (halt && !cmd_d.presc_clear && !reg_reset_d) |=> $stable(presc_q) && !sys_tick_q)
    else $error("prescaler ran while halted");

  // ****************************************
  // Register port and reset checks
  // ****************************************
  rd_flags_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.rd && reg_req.addr == `EFSR_OFS_FLAGS) |=> reg_rdata_q == $past(flags_q))
    else $error("flag read wrong");

  rd_minutes_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.rd && reg_req.addr == `EFSR_OFS_MINUTES)
      |=> reg_rdata_q == {$past(event_monitor_bit_q), 7'h00})
    else $error("event monitor read wrong");

  rd_cmd_zero_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.rd && reg_req.addr == `EFSR_OFS_RESET_CMD) |=> reg_rdata_q == 8'h00)
    else $error("command register read back");

  // Held so a slow serial shift-out sees one stable byte
  rd_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !reg_req.rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");

  no_write_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.wr && reg_req.addr != `EFSR_OFS_RESET_CMD) |=> cmd_q == '0)
    else $error("command from another address");

  // Only checked without a set, which would win
  flag_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (flags_wr && flag_set == 8'h00 && !reg_reset_d)
      |=> (flags_q & ~$past(reg_req.wdata)) == 8'h00)
    else $error("flag not cleared by zero");

  reset_pulse_one_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_reset_q && !cmd_wr) |=> !reg_reset_q)
    else $error("reset pulse too long");

  reset_only_soft_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_reset_q && state_q == EFSR_RUN && $past(state_q) == EFSR_RUN) |-> cmd_q.soft_reset)
    else $error("reset pulse without command");

  flag_rst_a: assert property (@(posedge mclk) disable iff (reset)
    reg_reset_q |-> flags_q == `EFSR_FLAGS_RST)
    else $error("flags not cleared by reset");

  event_monitor_bit_rst_a: assert property (@(posedge mclk) disable iff (reset)
    reg_reset_q |-> !event_monitor_bit_q)
    else $error("event monitor set after reset");

  // ****************************************
  // Prescaler checks
  // ****************************************
  // Clear acts even when running; the host is expected to halt first
  soft_presc_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_SOFT_RESET) |=> presc_q == '0 && !sys_tick_q)
    else $error("soft reset kept prescaler");

  both_presc_zero_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_BOTH_CLEAR) |=> presc_q == '0)
    else $error("combined clear kept prescaler");

  capt_no_presc_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_wr && reg_req.wdata == `EFSR_CMD_CAPT_CLEAR && !tick_8k192
      && state_q == EFSR_RUN) |=> $stable(presc_q))
    else $error("capture clear touched prescaler");

  halt_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (halt && cmd_d.presc_clear) |=> presc_q == '0)
    else $error("halted clear ignored");

  presc_rst_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(state_q == EFSR_RUN) |-> presc_q == '0)
    else $error("power-on kept prescaler");

  tick_wrap_a: assert property (@(posedge mclk) disable iff (reset)
    sys_tick_q |-> presc_q == '0)
    else $error("tick without wrap");

  // Wrap and clear excluded; they are checked on their own
  tick_count_a: assert property (@(posedge mclk) disable iff (reset)
    (tick_8k192 && !halt && !cmd_d.presc_clear && !reg_reset_d
      && presc_q != PW'(PRESC_DIV - 1)) |=> presc_q == $past(presc_q) + PW'(1))
    else $error("prescaler missed a step");

  tick_wraps_a: assert property (@(posedge mclk) disable iff (reset)
    (tick_8k192 && !halt && !cmd_d.presc_clear && !reg_reset_d
      && presc_q == PW'(PRESC_DIV - 1)) |=> sys_tick_q)
    else $error("system tick missing");

endmodule : efsr_top

// *** tb/efsr_host_model.sv ***
`timescale 1ns/10ps
// ****
// Host controller model
// ****
module efsr_host_model
  import efsr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output efsr_req_t reg_req,
  output logic halt
);
  initial begin
    reg_req = '0;
    halt = 1'b0;
  end
  // Held for one whole cycle; qualifiers drop together after the taking edge
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '0;
    #1;
  endtask : xfer
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = rdata;
  endtask : rd
  task automatic set_halt(input logic h);
    @(posedge mclk);
    halt <= h;
    #1;
  endtask : set_halt
  // Counting halted first so the restart is clean
  task automatic timed_clear();
    @(posedge mclk);
    halt <= 1'b1;
    wr(6'h2F, 8'hA4);
    halt <= 1'b0;
  endtask : timed_clear
endmodule : efsr_host_model

// *** tb/event_flags_and_soft_reset_tb.sv ***
`timescale 1ns/10ps
module event_flags_and_soft_reset_tb
  import efsr_pkg::*;
;
  logic mclk;
  logic reset;
  efsr_req_t reg_req;
  logic [7:0] flag_set;
  logic tick_8k192;
  logic halt;
  logic [7:0] reg_rdata_q;
  logic [7:0] flags_q;
  logic event_monitor_bit_q;
  efsr_cmd_t cmd_q;
  logic reg_reset_q;
  logic sys_tick_q;
  int err_count = 0;
  int n_checks = 0;
  int n_sys = 0;
  logic [7:0] d;

  // Short divider keeps the run brief
  efsr_top #(.PRESC_DIV(4)) efsr_top_inst (
    .mclk(mclk), .reset(reset), .reg_req(reg_req), .flag_set(flag_set),
    .tick_8k192(tick_8k192), .halt(halt), .reg_rdata_q(reg_rdata_q), .flags_q(flags_q),
    .event_monitor_bit_q(event_monitor_bit_q), .cmd_q(cmd_q), .reg_reset_q(reg_reset_q),
    .sys_tick_q(sys_tick_q)
  );
  efsr_host_model host (.mclk(mclk), .rdata(reg_rdata_q), .reg_req(reg_req), .halt(halt));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (sys_tick_q === 1'b1) n_sys++;
  end

  // ****
  // Checking and closing
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // ****
  // Scenarios
  // ****
  task automatic pulse_flags(input logic [7:0] v);
    @(posedge mclk);
    flag_set <= v;
    @(posedge mclk);
    flag_set <= 8'h00;
    #1;
  endtask : pulse_flags
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      tick_8k192 <= 1'b1;
      @(posedge mclk);
      tick_8k192 <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask : ticks
  task automatic bit_layout();
    for (int i = 0; i < 8; i++) begin
      pulse_flags(8'h01 << i);
      host.rd(6'h2B, d);
      chk(d, 8'h01 << i);
      host.wr(6'h2B, ~(8'h01 << i));
      chk(flags_q, 8'h00);
    end
  endtask : bit_layout
  task automatic and_write();
    pulse_flags(8'hFF);
    host.wr(6'h2B, 8'h5A);
    chk(flags_q, 8'h5A);
    chk({7'h00, event_monitor_bit_q}, 8'h01);
    host.rd(6'h02, d);
    chk(d, 8'h80);
    // Clearing write and a new event in one cycle
    fork
      host.wr(6'h2B, 8'h00);
      pulse_flags(8'h01);
    join
    chk(flags_q, 8'h01);
    host.wr(6'h2B, 8'h00);
    host.rd(6'h02, d);
    chk(d, 8'h00);
  endtask : and_write
  task automatic commands();
    logic [7:0] code [7] = '{8'h2C, 8'hA4, 8'h25, 8'hA5, 8'h00, 8'hFF, 8'h2D};
    logic [2:0] exp [7] = '{3'b111, 3'b010, 3'b001, 3'b011, 3'b000, 3'b000, 3'b000};
    for (int i = 0; i < 7; i++) begin
      pulse_flags(8'h81);
      host.wr(6'h2F, code[i]);
      chk({5'h00, cmd_q}, {5'h00, exp[i]});
      chk({7'h00, reg_reset_q}, {7'h00, exp[i][2]});
      chk(flags_q, exp[i][2] ? 8'h00 : 8'h81);
      @(posedge mclk);
      #1;
      chk({5'h00, cmd_q}, 8'h00);
      host.wr(6'h2B, 8'h00);
    end
    host.rd(6'h2F, d);
    chk(d, 8'h00);
    host.rd(6'h3F, d);
    chk(d, 8'h00);
  endtask : commands
  task automatic prescaler();
    int n0;
    n0 = n_sys;
    ticks(3);
    chk(8'(n_sys - n0), 8'h00);
    ticks(1);
    chk(8'(n_sys - n0), 8'h01);
    ticks(2);
    host.set_halt(1'b1);
    ticks(4);
    chk(8'(n_sys - n0), 8'h01);
    host.timed_clear();
    ticks(3);
    chk(8'(n_sys - n0), 8'h01);
    ticks(1);
    chk(8'(n_sys - n0), 8'h02);
  endtask : prescaler
  task automatic power_on();
    @(posedge mclk);
    #1;
    chk({7'h00, reg_reset_q}, 8'h01);
    chk(flags_q, 8'h00);
    chk({7'h00, event_monitor_bit_q}, 8'h00);
    host.rd(6'h2B, d);
    chk(d, 8'h00);
  endtask : power_on
  task automatic mid_reset();
    pulse_flags(8'h3C);
    chk({7'h00, event_monitor_bit_q}, 8'h01);
    @(posedge mclk);
    reset <= 1'b1;
    #1;
    chk(flags_q, 8'h00);
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    power_on();
  endtask : mid_reset

  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    flag_set = 8'h00;
    tick_8k192 = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    power_on();
    bit_layout();
    and_write();
    commands();
    prescaler();
    mid_reset();
    wrap_up();
  end
endmodule : event_flags_and_soft_reset_tb
